// [hw/ccs_pkg.sv]
package ccs_pkg;
	// Reference clock rate
	localparam int unsigned CLK_HZ = 40000000;
	// Switching frequency select codes
	localparam logic [1:0] FREQ_300K = 2'h0;
	localparam logic [1:0] FREQ_400K = 2'h1;
	localparam logic [1:0] FREQ_600K = 2'h2;
	localparam logic [1:0] FREQ_800K = 2'h3;
	localparam logic [1:0] FREQ_RST = FREQ_800K;
	localparam int unsigned F300_HZ = 300000;
	localparam int unsigned F400_HZ = 400000;
	localparam int unsigned F600_HZ = 600000;
	localparam int unsigned F800_HZ = 800000;
	// Cycle lengths in clocks per switching period
	localparam logic [7:0] PER_300K = 8'(CLK_HZ / F300_HZ);
	localparam logic [7:0] PER_400K = 8'(CLK_HZ / F400_HZ);
	localparam logic [7:0] PER_600K = 8'(CLK_HZ / F600_HZ);
	localparam logic [7:0] PER_800K = 8'(CLK_HZ / F800_HZ);
	// Dead time in clocks
	localparam logic [3:0] DEAD_CYC = 4'h2;
	// Watchdog select codes and periods
	localparam logic [1:0] WD_OFF = 2'h0;
	localparam logic [1:0] WD_5S = 2'h1;
	localparam logic [1:0] WD_78S = 2'h2;
	localparam logic [1:0] WD_155S = 2'h3;
	localparam logic [1:0] WD_RST = WD_155S;
	localparam longint unsigned WD_5S_SEC = 5;
	localparam longint unsigned WD_78S_SEC = 78;
	localparam longint unsigned WD_155S_SEC = 155;
	// Deglitch and response times
	localparam int unsigned OCP_DEG_US = 6000;
	localparam int unsigned OVP_DEG_US = 30000;
	localparam int unsigned BATREM_US = 100;
	localparam longint unsigned OCP_DEG_CYC = longint'(CLK_HZ) * OCP_DEG_US / 1000000 + 1;
	localparam longint unsigned OVP_DEG_CYC = longint'(CLK_HZ) * OVP_DEG_US / 1000000 + 1;
	// Charge current setting limits selecting 6A, 9A, 12A peak thresholds
	localparam logic [6:0] CHG_LIM_LO = 7'h20;
	localparam logic [6:0] CHG_LIM_MID = 7'h40;
	localparam logic [1:0] OCP_6A = 2'h0;
	localparam logic [1:0] OCP_9A = 2'h1;
	localparam logic [1:0] OCP_12A = 2'h2;

	// Converter mode
	typedef enum logic [1:0] {
		CCS_MODE_CHARGE = 2'h0,
		CCS_MODE_HYBRID = 2'h1,
		CCS_MODE_BOOST = 2'h2,
		CCS_MODE_IDLE = 2'h3
	} ccs_mode_t;

	// Gate phase, one-hot
	typedef enum logic [3:0] {
		PH_HS = 4'b0001,
		PH_DT1 = 4'b0010,
		PH_LS = 4'b0100,
		PH_DT2 = 4'b1000
	} ccs_phase_t;

	// Analog comparator inputs
	typedef struct packed {
		logic eao_above_ramp;
		logic ls_under_current;
		logic chg_below_125ma;
		logic chg_above_250ma;
		logic dchg_below_300ma;
		logic dchg_above_550ma;
		logic ocp_over_6a;
		logic ocp_over_9a;
		logic ocp_over_12a;
		logic input_over_1p25;
		logic input_over_2;
		logic battery_overvoltage;
		logic battery_depleted;
		logic adapter_detect;
		logic battery_present_n;
	} ccs_sense_t;

	// Switch drives
	typedef struct packed {
		logic high_side_switch;
		logic low_side_switch;
		logic adapter_switch;
		logic reverse_block_switch;
		logic battery_switch;
		logic srp_sink;
	} ccs_drive_t;
endpackage

// [hw/ccs_deglitch.sv]
`timescale 1ns/1ps
// Counts while the condition holds; restarts from zero once it clears
module ccs_deglitch #(
	parameter longint unsigned LIMIT = 64'd16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Condition and expiry
	input wire logic cond_i,
	output logic expired_o
);
	typedef struct packed {
		logic [23:0] cnt;
		logic done;
	} ccs_dg_t;
	ccs_dg_t st_ff;
	ccs_dg_t nxt_st;

	// Counter with restart on clear
	always_comb begin
		nxt_st = st_ff;
		if (!cond_i) begin
			nxt_st.cnt = 24'h0;
			nxt_st.done = 1'b0;
		end else if (64'(st_ff.cnt) >= LIMIT - 1) begin
			nxt_st.done = 1'b1;
		end else begin
			nxt_st.cnt = st_ff.cnt + 24'h1;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign expired_o = st_ff.done;
endmodule

// [hw/ccs_top.sv]
`timescale 1ns/1ps
// Summary of operation
// - Switching period picked from 300/400/600/800kHz by two bits, 800kHz after reset.
// - High side on at cycle start until ramp passes error amp, then low side.
// - Dead time with both switches off at every transition.
// - Low side off for rest of cycle when its current drops below 0.54A.
// - Charge light load below 125mA keeps low side off until above 250mA.
// - Boost light load below 300mA keeps high side off until above 550mA.
// - Calibration enable turns adapter switches off and battery switch on.
// - Battery depletion ends calibration, restores adapter, clears enable.
// - Adapter removal clears calibration enable; battery switch stays on.
// - Battery removal ends calibration; adapter switches on within 100us.
// - Watchdog timeout suspends charge and boost unless restarted by writes.
// - Watchdog period 155s default, 78s, 5s or off; change restarts it.
// - Timeout keeps settings; suspended until a restart event.
// - Input limit 1.25x or 2x critical current; enable bit can disable it.
// - Over-current beyond 6ms latches adapter switches off until adapter removed.
// - Peak charge threshold 6A, 9A or 12A from charge current setting.
// - Peak over-current turns high side off until next cycle start.
// - Charge overvoltage holds both off; beyond 30ms disables charger.
// - Discharge sink enabled while battery overvoltage is present in charge mode.
// - Battery overvoltage ignored during boost modes.
module ccs_top #(
	parameter longint unsigned WD_SCALE = 64'd40000000,
	parameter longint unsigned OCP_CYC = ccs_pkg::OCP_DEG_CYC,
	parameter longint unsigned OVP_CYC = ccs_pkg::OVP_DEG_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Host settings
	input wire logic [1:0] switching_freq_select_i,
	input wire logic [1:0] watchdog_period_select_i,
	input wire logic input_ocp_threshold_select_i,
	input wire logic input_ocp_enable_i,
	input wire logic [6:0] charge_current_setting_i,
	input wire logic charge_write_i,
	input wire ccs_pkg::ccs_mode_t mode_i,
	input wire logic calibration_enable_set_i,
	// Analog comparators and pins
	input wire ccs_pkg::ccs_sense_t sense_i,
	// Switch drives
	output ccs_pkg::ccs_drive_t drive_o,
	// Status
	output logic calibration_discharge_enable_o,
	output logic watchdog_expired_o,
	output logic input_overcurrent_latched_o,
	output logic charger_disabled_o,
	output logic [1:0] charge_ocp_level_o
);
	typedef struct packed {
		ccs_pkg::ccs_sense_t s1;
		ccs_pkg::ccs_sense_t s2;
		ccs_pkg::ccs_sense_t s3;
		ccs_pkg::ccs_sense_t sv;
		ccs_pkg::ccs_phase_t phase;
		logic [7:0] cyc;
		logic [3:0] dead;
		logic ls_cut;
		logic hs_cut;
		logic ll_chg;
		logic ll_bst;
		logic cal_en;
		logic bat_prev_n;
		logic [39:0] wd_cnt;
		logic [1:0] wd_sel;
		logic wd_exp;
		logic ocp_latch;
		logic chg_dis;
		logic [1:0] ocp_lvl;
		ccs_pkg::ccs_drive_t drv;
	} ccs_st_t;

	ccs_st_t st_ff;
	ccs_st_t nxt_st;
	logic ocp_exp;
	logic ovp_exp;
	logic in_oc;
	logic ovp_active;

	// Cycle length for a frequency code
	function automatic logic [7:0] period_of(input logic [1:0] sel);
		case (sel)
			ccs_pkg::FREQ_300K: period_of = ccs_pkg::PER_300K;
			ccs_pkg::FREQ_400K: period_of = ccs_pkg::PER_400K;
			ccs_pkg::FREQ_600K: period_of = ccs_pkg::PER_600K;
			default: period_of = ccs_pkg::PER_800K;
		endcase
	endfunction

	// Watchdog limit for a period code, zero when off
	function automatic logic [39:0] wd_limit(input logic [1:0] sel);
		case (sel)
			ccs_pkg::WD_5S: wd_limit = 40'(ccs_pkg::WD_5S_SEC * WD_SCALE);
			ccs_pkg::WD_78S: wd_limit = 40'(ccs_pkg::WD_78S_SEC * WD_SCALE);
			ccs_pkg::WD_155S: wd_limit = 40'(ccs_pkg::WD_155S_SEC * WD_SCALE);
			default: wd_limit = 40'h0;
		endcase
	endfunction

	// Input over-current at the chosen multiple, gated by enable
	assign in_oc = input_ocp_enable_i && (input_ocp_threshold_select_i ? st_ff.sv.input_over_2
		: st_ff.sv.input_over_1p25);
	// Overvoltage counts only while charging
	assign ovp_active = st_ff.sv.battery_overvoltage && (mode_i == ccs_pkg::CCS_MODE_CHARGE);

	ccs_deglitch #(
		.LIMIT(OCP_CYC)
	) u_ocp_dg (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.cond_i(in_oc),
		.expired_o(ocp_exp)
	);

	ccs_deglitch #(
		.LIMIT(OVP_CYC)
	) u_ovp_dg (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.cond_i(ovp_active),
		.expired_o(ovp_exp)
	);

	// Next-state logic
	always_comb begin
		logic cyc_end;
		logic run;
		logic chg;
		logic bst;
		logic peak_oc;
		logic bat_rise;
		cyc_end = 1'b0;
		run = 1'b0;
		chg = 1'b0;
		bst = 1'b0;
		peak_oc = 1'b0;
		bat_rise = 1'b0;
		nxt_st = st_ff;

		// Three-stage sampling; accept a change when stages two and three agree
		nxt_st.s1 = sense_i;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		for (int i = 0; i < $bits(ccs_pkg::ccs_sense_t); i++) begin
			if (st_ff.s2[i] == st_ff.s3[i]) begin
				nxt_st.sv[i] = st_ff.s3[i];
			end
		end

		// Peak threshold chosen from the charge current setting
		if (charge_current_setting_i < ccs_pkg::CHG_LIM_LO) begin
			nxt_st.ocp_lvl = ccs_pkg::OCP_6A;
		end else if (charge_current_setting_i < ccs_pkg::CHG_LIM_MID) begin
			nxt_st.ocp_lvl = ccs_pkg::OCP_9A;
		end else begin
			nxt_st.ocp_lvl = ccs_pkg::OCP_12A;
		end
		case (st_ff.ocp_lvl)
			ccs_pkg::OCP_6A: peak_oc = st_ff.sv.ocp_over_6a;
			ccs_pkg::OCP_9A: peak_oc = st_ff.sv.ocp_over_9a;
			default: peak_oc = st_ff.sv.ocp_over_12a;
		endcase

		// Watchdog: restart on writes or period change, stop at timeout
		nxt_st.wd_sel = watchdog_period_select_i;
		if (charge_write_i || (watchdog_period_select_i != st_ff.wd_sel)) begin
			nxt_st.wd_cnt = 40'h0;
			nxt_st.wd_exp = 1'b0;
		end else if (st_ff.wd_sel == ccs_pkg::WD_OFF) begin
			nxt_st.wd_cnt = 40'h0;
			nxt_st.wd_exp = 1'b0;
		end else if (!st_ff.wd_exp) begin
			if (st_ff.wd_cnt + 40'h1 >= wd_limit(st_ff.wd_sel)) begin
				nxt_st.wd_exp = 1'b1;
			end else begin
				nxt_st.wd_cnt = st_ff.wd_cnt + 40'h1;
			end
		end

		// Input over-current latch, cleared by adapter removal; a fresh trip wins
		if (ocp_exp) begin
			nxt_st.ocp_latch = 1'b1;
		end else if (!st_ff.sv.adapter_detect) begin
			nxt_st.ocp_latch = 1'b0;
		end

		// Overvoltage beyond the deglitch disables the charger
		if (ovp_exp) begin
			nxt_st.chg_dis = 1'b1;
		end

		// Calibration discharge control
		bat_rise = st_ff.sv.battery_present_n && !st_ff.bat_prev_n;
		nxt_st.bat_prev_n = st_ff.sv.battery_present_n;
		if (st_ff.cal_en && (!st_ff.sv.adapter_detect || st_ff.sv.battery_depleted || bat_rise)) begin
			nxt_st.cal_en = 1'b0;
		end else if (calibration_enable_set_i && st_ff.sv.adapter_detect) begin
			nxt_st.cal_en = 1'b1;
		end

		// Path switches
		nxt_st.drv.adapter_switch = st_ff.sv.adapter_detect && !st_ff.ocp_latch && !nxt_st.cal_en
			&& !(st_ff.sv.input_over_1p25 && ocp_exp && input_ocp_enable_i);
		nxt_st.drv.reverse_block_switch = nxt_st.drv.adapter_switch;
		nxt_st.drv.battery_switch = nxt_st.cal_en || !st_ff.sv.adapter_detect
			|| mode_i == ccs_pkg::CCS_MODE_HYBRID || mode_i == ccs_pkg::CCS_MODE_BOOST;
		nxt_st.drv.srp_sink = st_ff.sv.battery_overvoltage && mode_i == ccs_pkg::CCS_MODE_CHARGE;

		// Light-load hysteresis
		if (st_ff.sv.chg_below_125ma) begin
			nxt_st.ll_chg = 1'b1;
		end else if (st_ff.sv.chg_above_250ma) begin
			nxt_st.ll_chg = 1'b0;
		end
		if (st_ff.sv.dchg_below_300ma) begin
			nxt_st.ll_bst = 1'b1;
		end else if (st_ff.sv.dchg_above_550ma) begin
			nxt_st.ll_bst = 1'b0;
		end

		// Converter allowed to switch
		chg = mode_i == ccs_pkg::CCS_MODE_CHARGE && !st_ff.chg_dis && !ovp_active;
		bst = mode_i == ccs_pkg::CCS_MODE_HYBRID || mode_i == ccs_pkg::CCS_MODE_BOOST;
		run = (chg || bst) && !st_ff.wd_exp;

		// Switching cycle counter
		if (st_ff.cyc + 8'h1 >= period_of(switching_freq_select_i)) begin
			nxt_st.cyc = 8'h0;
			cyc_end = 1'b1;
		end else begin
			nxt_st.cyc = st_ff.cyc + 8'h1;
		end

		// Per-cycle cut flags
		if (cyc_end) begin
			nxt_st.ls_cut = 1'b0;
			nxt_st.hs_cut = 1'b0;
		end else begin
			if (st_ff.phase == ccs_pkg::PH_LS && st_ff.sv.ls_under_current) begin
				nxt_st.ls_cut = 1'b1;
			end
			if (peak_oc) begin
				nxt_st.hs_cut = 1'b1;
			end
		end

		// Gate phase sequencing with dead time
		nxt_st.dead = (st_ff.dead != 4'h0) ? st_ff.dead - 4'h1 : 4'h0;
		case (st_ff.phase)
			ccs_pkg::PH_HS: begin
				if (!st_ff.sv.eao_above_ramp || cyc_end || peak_oc) begin
					nxt_st.phase = ccs_pkg::PH_DT1;
					nxt_st.dead = ccs_pkg::DEAD_CYC;
				end
			end
			ccs_pkg::PH_DT1: begin
				if (cyc_end) begin
					nxt_st.phase = ccs_pkg::PH_DT2;
					nxt_st.dead = ccs_pkg::DEAD_CYC;
				end else if (st_ff.dead == 4'h0) begin
					nxt_st.phase = ccs_pkg::PH_LS;
				end
			end
			ccs_pkg::PH_LS: begin
				if (cyc_end) begin
					nxt_st.phase = ccs_pkg::PH_DT2;
					nxt_st.dead = ccs_pkg::DEAD_CYC;
				end
			end
			ccs_pkg::PH_DT2: begin
				if (st_ff.dead == 4'h0) begin
					nxt_st.phase = ccs_pkg::PH_HS;
				end
			end
			default: begin
				nxt_st.phase = ccs_pkg::PH_DT2;
			end
		endcase

		// Gate outputs: only in their phase, never together
		nxt_st.drv.high_side_switch = run && nxt_st.phase == ccs_pkg::PH_HS
			&& !nxt_st.hs_cut && !(bst && st_ff.ll_bst);
		nxt_st.drv.low_side_switch = run && nxt_st.phase == ccs_pkg::PH_LS && !nxt_st.ls_cut
			&& !(chg && st_ff.ll_chg);
	end

	// State register
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_ff <= '0;
			st_ff.phase <= ccs_pkg::PH_DT2;
			st_ff.dead <= ccs_pkg::DEAD_CYC;
			st_ff.wd_sel <= ccs_pkg::WD_RST;
			st_ff.bat_prev_n <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from state
	assign drive_o = st_ff.drv;
	assign calibration_discharge_enable_o = st_ff.cal_en;
	assign watchdog_expired_o = st_ff.wd_exp;
	assign input_overcurrent_latched_o = st_ff.ocp_latch;
	assign charger_disabled_o = st_ff.chg_dis;
	assign charge_ocp_level_o = st_ff.ocp_lvl;
endmodule

// [tb/ccs_top_properties.sv]
`timescale 1ns/1ps
// Port-level checks of the charger supervisor
module ccs_top_properties #(
	parameter longint unsigned WD_SCALE = 64'd40000000,
	parameter longint unsigned OCP_CYC = 64'd20,
	parameter longint unsigned OVP_CYC = 64'd40
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Settings and sense
	input wire logic input_ocp_threshold_select_i,
	input wire logic input_ocp_enable_i,
	input wire logic [6:0] charge_current_setting_i,
	input wire ccs_pkg::ccs_sense_t sense_i,
	// Outputs
	input wire ccs_pkg::ccs_drive_t drive_o,
	input wire logic calibration_discharge_enable_o,
	input wire logic watchdog_expired_o,
	input wire logic input_overcurrent_latched_o,
	input wire logic charger_disabled_o,
	input wire logic [1:0] charge_ocp_level_o
);
	logic [15:0] run_ff;
	logic [3:0] gap_ff;
	logic [1:0] lvl_exp;
	logic raw_ocp;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// Expected peak threshold and raw over-current condition
	always_comb begin
		lvl_exp = ccs_pkg::OCP_12A;
		if (charge_current_setting_i < ccs_pkg::CHG_LIM_MID) lvl_exp = ccs_pkg::OCP_9A;
		if (charge_current_setting_i < ccs_pkg::CHG_LIM_LO) lvl_exp = ccs_pkg::OCP_6A;
		raw_ocp = input_ocp_enable_i && (input_ocp_threshold_select_i ?
			sense_i.input_over_2 : sense_i.input_over_1p25);
	end
	// Run length of the over-current, tolerant of short sampling gaps
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			run_ff <= '0;
			gap_ff <= '0;
		end else if (raw_ocp) begin
			run_ff <= run_ff + 16'h1;
			gap_ff <= '0;
		end else if (gap_ff == 4'h8) begin
			run_ff <= '0;
		end else begin
			run_ff <= run_ff + 16'h1;
			gap_ff <= gap_ff + 4'h1;
		end
	end
	chk_no_overlap: assert property (
		!(drive_o.high_side_switch && drive_o.low_side_switch))
		else $error("both gate drives on");
	chk_hs_dead: assert property ($fell(drive_o.high_side_switch) |->
		!drive_o.low_side_switch[*2])
		else $error("no dead time after high side");
	chk_ls_dead: assert property ($fell(drive_o.low_side_switch) |->
		!drive_o.high_side_switch[*2])
		else $error("no dead time after low side");
	chk_ocp_level: assert property (1'b1 |=> charge_ocp_level_o == $past(lvl_exp))
		else $error("peak threshold level wrong");
	chk_disable_sticky: assert property (charger_disabled_o |=> charger_disabled_o)
		else $error("charger disable cleared");
	chk_ovp_gates: assert property (charger_disabled_o[*3] |->
		!(drive_o.high_side_switch || drive_o.low_side_switch))
		else $error("switching while disabled");
	chk_wd_suspend: assert property (watchdog_expired_o[*3] |->
		!(drive_o.high_side_switch || drive_o.low_side_switch))
		else $error("switching after watchdog timeout");
	chk_latch_off: assert property (input_overcurrent_latched_o[*3] |->
		!(drive_o.adapter_switch || drive_o.reverse_block_switch))
		else $error("adapter path on while latched");
	chk_ocp_min: assert property ($rose(input_overcurrent_latched_o) |->
		run_ff >= OCP_CYC)
		else $error("over-current latched too early");
	chk_cal_path: assert property (calibration_discharge_enable_o[*3] |->
		!drive_o.adapter_switch && drive_o.battery_switch)
		else $error("calibration path wrong");
	// Main scenarios
	cov_cal: cover property ($rose(calibration_discharge_enable_o));
	cov_wd: cover property ($rose(watchdog_expired_o));
	cov_latch: cover property ($rose(input_overcurrent_latched_o));
	cov_dis: cover property ($rose(charger_disabled_o));
endmodule
bind ccs_top ccs_top_properties #(.WD_SCALE(WD_SCALE), .OCP_CYC(OCP_CYC), .OVP_CYC(OVP_CYC)) u_chk (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .input_ocp_threshold_select_i(input_ocp_threshold_select_i),
	.input_ocp_enable_i(input_ocp_enable_i), .charge_current_setting_i(charge_current_setting_i),
	.sense_i(sense_i), .drive_o(drive_o), .calibration_discharge_enable_o(calibration_discharge_enable_o),
	.watchdog_expired_o(watchdog_expired_o), .input_overcurrent_latched_o(input_overcurrent_latched_o),
	.charger_disabled_o(charger_disabled_o), .charge_ocp_level_o(charge_ocp_level_o));

// [tb/ccs_stage_model.sv]
`timescale 1ns/1ps
// Power stage and error amplifier: ramp passes the amplifier DUTY clocks into high-side on time
module ccs_stage_model #(
	parameter int DUTY = 20
) (
	// Clock
	input wire logic clk_i,
	// Gate drives and comparator
	input wire ccs_pkg::ccs_drive_t drive_i,
	output logic eao_above_ramp_o
);
	int cnt = 0;
	// Ramp restarts whenever the high side is off
	always @(posedge clk_i) begin
		cnt <= drive_i.high_side_switch ? cnt + 1 : 0;
	end
	assign eao_above_ramp_o = (cnt < DUTY);
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [1:0] fsel = 2'h3;
	logic [1:0] wsel = 2'h0;
	logic othr = 1'b0;
	logic oen = 1'b1;
	logic [6:0] cset = 7'h00;
	logic cwr = 1'b0;
	logic calset = 1'b0;
	logic error_amp_output;
	logic cal_en, wd_exp, iocp, dis;
	logic [1:0] lvl;
	ccs_pkg::ccs_mode_t mode = ccs_pkg::CCS_MODE_CHARGE;
	ccs_pkg::ccs_sense_t sn = '0;
	ccs_pkg::ccs_sense_t sense;
	ccs_pkg::ccs_drive_t drv;
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int n, h, l, hb;
	logic [7:0] per_tab [4] = '{ccs_pkg::PER_300K, ccs_pkg::PER_400K, ccs_pkg::PER_600K,
		ccs_pkg::PER_800K};
	logic [6:0] set_tab [5] = '{7'h1f, 7'h20, 7'h3f, 7'h40, 7'h7f};
	logic [1:0] lvl_tab [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
	ccs_top #(.WD_SCALE(64'd10), .OCP_CYC(64'd20), .OVP_CYC(64'd40)) uut (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .switching_freq_select_i(fsel), .watchdog_period_select_i(wsel),
		.input_ocp_threshold_select_i(othr), .input_ocp_enable_i(oen),
		.charge_current_setting_i(cset), .charge_write_i(cwr), .mode_i(mode),
		.calibration_enable_set_i(calset), .sense_i(sense), .drive_o(drv),
		.calibration_discharge_enable_o(cal_en), .watchdog_expired_o(wd_exp),
		.input_overcurrent_latched_o(iocp), .charger_disabled_o(dis), .charge_ocp_level_o(lvl));
	ccs_stage_model #(.DUTY(20)) u_stage (.clk_i(clk_i), .drive_i(drv), .eao_above_ramp_o(error_amp_output));
	// Comparator bundle with the amplifier from the stage model
	always_comb begin
		sense = sn;
		sense.eao_above_ramp = error_amp_output;
	end
	always #12.5 clk_i = ~clk_i;
	// Hang guard
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Inputs move 2 ns after the rising edge
	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#2;
	endtask
	task automatic pulse_cal();
		calset = 1'b1;
		tick(1);
		calset = 1'b0;
		tick(8);
	endtask
	// Clocks from one high-side turn-on to the next
	task automatic period(output int p);
		int k;
		for (k = 0; k < 400 && drv.high_side_switch !== 1'b0; k++) tick(1);
		for (k = 0; k < 400 && drv.high_side_switch !== 1'b1; k++) tick(1);
		for (p = 0; p < 400 && drv.high_side_switch === 1'b1; p++) tick(1);
		for (k = 0; k < 400 && drv.high_side_switch !== 1'b1; k++) tick(1);
		p += k;
	endtask
	// High-side and low-side on cycles over a window, after settling
	task automatic ontime(output int ho, output int lo);
		ho = 0;
		lo = 0;
		tick(60);
		repeat (100) begin
			tick(1);
			ho += int'(drv.high_side_switch);
			lo += int'(drv.low_side_switch);
		end
	endtask
	task automatic light(input logic below, input logic above);
		if (mode == ccs_pkg::CCS_MODE_CHARGE) {sn.chg_below_125ma, sn.chg_above_250ma} = {below, above};
		else {sn.dchg_below_300ma, sn.dchg_above_550ma} = {below, above};
		ontime(h, l);
	endtask
	initial begin
		sn.adapter_detect = 1'b1;
		sn.chg_above_250ma = 1'b1;
		sn.dchg_above_550ma = 1'b1;
		tick(10);
		check(16'(drv), 16'h0);
		sys_rst_i = 1'b0;
		tick(10);
		for (int i = 3; i >= 0; i--) begin
			fsel = 2'(i);
			tick(300);
			period(n);
			check(16'(n), 16'(per_tab[i]));
		end
		fsel = 2'h3;
		ontime(hb, l);
		check(16'(hb >= 20 && l > 0), 16'h1);
		for (int m = 0; m < 2; m++) begin
			mode = m ? ccs_pkg::CCS_MODE_BOOST : ccs_pkg::CCS_MODE_CHARGE;
			light(1'b1, 1'b0);
			check(16'(m ? h : l), 16'h0);
			light(1'b0, 1'b0);
			check(16'(m ? h : l), 16'h0);
			light(1'b0, 1'b1);
			check(16'((m ? h : l) > 0), 16'h1);
		end
		mode = ccs_pkg::CCS_MODE_CHARGE;
		sn.ls_under_current = 1'b1;
		ontime(h, l);
		// Low side needs one clock on per switching cycle to sense its current, then stays cut until cycle end
		check(16'(l <= 2), 16'h1);
		sn.ls_under_current = 1'b0;
		for (int i = 0; i < 5; i++) begin
			cset = set_tab[i];
			tick(2);
			check(16'(lvl), 16'(lvl_tab[i]));
		end
		sn.ocp_over_6a = 1'b1;
		ontime(h, l);
		check(16'(h * 2 >= hb), 16'h1);
		cset = 7'h00;
		ontime(h, l);
		check(16'(h * 2 < hb), 16'h1);
		sn.ocp_over_6a = 1'b0;
		sn.adapter_detect = 1'b0;
		tick(10);
		pulse_cal();
		check(16'(cal_en), 16'h0);
		sn.adapter_detect = 1'b1;
		tick(10);
		pulse_cal();
		check(16'({cal_en, drv.adapter_switch, drv.reverse_block_switch, drv.battery_switch}),
			16'h9);
		sn.battery_depleted = 1'b1;
		tick(10);
		check(16'({cal_en, drv.adapter_switch}), 16'h1);
		sn.battery_depleted = 1'b0;
		tick(4);
		pulse_cal();
		sn.adapter_detect = 1'b0;
		n = 0;
		repeat (20) begin
			tick(1);
			n += int'(drv.battery_switch);
		end
		check(16'({cal_en, 5'(n)}), 16'h14);
		sn.adapter_detect = 1'b1;
		tick(10);
		check(16'(cal_en), 16'h0);
		pulse_cal();
		sn.battery_present_n = 1'b1;
		tick(10);
		check(16'({cal_en, drv.adapter_switch, drv.reverse_block_switch}), 16'h3);
		sn.battery_present_n = 1'b0;
		for (int i = 0; i < 2; i++) begin
			sn.input_over_1p25 = 1'b1;
			tick(15);
			sn.input_over_1p25 = 1'b0;
			tick(3);
		end
		tick(10);
		check(16'(iocp), 16'h0);
		sn.input_over_1p25 = 1'b1;
		tick(40);
		check(16'({iocp, drv.adapter_switch, drv.reverse_block_switch}), 16'h4);
		sn.input_over_1p25 = 1'b0;
		tick(10);
		check(16'(iocp), 16'h1);
		sn.adapter_detect = 1'b0;
		tick(10);
		check(16'(iocp), 16'h0);
		sn.adapter_detect = 1'b1;
		othr = 1'b1;
		sn.input_over_1p25 = 1'b1;
		tick(40);
		check(16'(iocp), 16'h0);
		oen = 1'b0;
		sn.input_over_2 = 1'b1;
		tick(40);
		check(16'(iocp), 16'h0);
		{sn.input_over_1p25, sn.input_over_2} = 2'h0;
		wsel = 2'h1;
		tick(40);
		wsel = 2'h2;
		tick(40);
		wsel = 2'h1;
		tick(40);
		check(16'(wd_exp), 16'h0);
		tick(30);
		check(16'({wd_exp, lvl}), 16'h4);
		check(16'({drv.high_side_switch, drv.low_side_switch}), 16'h0);
		cwr = 1'b1;
		tick(1);
		cwr = 1'b0;
		tick(3);
		check(16'(wd_exp), 16'h0);
		wsel = 2'h0;
		tick(200);
		check(16'(wd_exp), 16'h0);
		// Both boost flavours keep switching through an overvoltage
		for (int m = 0; m < 2; m++) begin
			mode = m ? ccs_pkg::CCS_MODE_HYBRID : ccs_pkg::CCS_MODE_BOOST;
			sn.battery_overvoltage = 1'b1;
			ontime(h, l);
			check(16'({dis, 1'(h > 0)}), 16'h1);
		end
		sn.battery_overvoltage = 1'b0;
		mode = ccs_pkg::CCS_MODE_CHARGE;
		tick(10);
		sn.battery_overvoltage = 1'b1;
		tick(10);
		check(16'(drv.srp_sink), 16'h1);
		check(16'({drv.high_side_switch, drv.low_side_switch}), 16'h0);
		tick(20);
		sn.battery_overvoltage = 1'b0;
		tick(20);
		check(16'(dis), 16'h0);
		sn.battery_overvoltage = 1'b1;
		tick(60);
		check(16'(dis), 16'h1);
		tally_and_finish();
	end
endmodule
